// ---- rtl/gport_master.sv ----
// Graphics master end: configuration claim and pipelined request issue
// Operation
// - Claim config only with AD1:0 zero, select
// - Port mode: config select derived from address line 16
// - Port-only: claim when AD16 one, AD1:0 zero
// - All other cases leave claim deasserted
// - Multifunction header selects function from AD10:8
// - Software scans spaces via AD16..AD31 lines
// - Strap picks port mode or external select
// - Fast write inbound at port rate only
// - Only main-memory reads/writes are pipelined
// - Requests framed by pipe signal, not frame
// - Pipeline depth never exceeds 256
// - Outstanding never exceeds advertised target slots
// - From idle: arbitrate, then back-to-back requests
// - Pipe release with requests enters DATA
// - Arbiter suspends data, grants on request
// - Data suspended only between transactions
// - DATA holds until all data returned, a new request or a frame
// - Mobile clock stops only in IDLE
// - Memory controller is sole pipelined target
// - No subtractive decoding for frame transactions
// - Corelogic exempt from target latency limits
// - Status lines qualify each grant
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module gport_master (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Link
  gport_if.master                       link,
  // Strap and configuration
  input  wire logic                     port_mode_strap,
  input  wire logic                     ext_cfg_select,
  input  wire logic                     header_multi,
  input  wire logic [gport_pkg::DEPTH_W-1:0] target_slots,
  input  wire logic                     accelerated_target_write,
  // User request port
  input  wire logic                     user_req_valid,
  input  wire logic [gport_pkg::AD_W-1:0]  user_req_addr,
  input  wire logic [gport_pkg::CBE_W-1:0] user_req_cmd,
  input  wire logic                     user_req_main_mem,
  output logic                          user_req_ready,
  // Status
  output logic                          cfg_hit,
  output logic [2:0]                    cfg_function,
  output logic [gport_pkg::DEPTH_W-1:0] outstanding,
  output gport_pkg::bus_state_e         bus_state,
  output logic                          port_mode,
  output logic                          fast_write_active,
  output logic                          clock_stop_ok
);
  import gport_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and configuration select

  logic mode_seen;
  logic next_mode_seen;
  logic next_port_mode;
  logic cfg_select;
  logic claim_now;
  logic [2:0] next_cfg_function;
  logic next_cfg_hit;

  // Strap caught once after reset release, not under reset itself
  always_comb begin
    next_mode_seen = 1'b1;
    next_port_mode = mode_seen ? port_mode : port_mode_strap;
  end

  // Strap and capture flag registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_seen <= 1'b0;
      port_mode <= 1'b1;
    end else begin
      mode_seen <= next_mode_seen;
      port_mode <= next_port_mode;
    end
  end

  // Port mode uses AD16 internally; PCI mode takes the outside select pin
  assign cfg_select = port_mode ? link.ad[CFG_SELECT_BIT] : ext_cfg_select;
  // Positive decode only, so no subtractive claim late in the frame
  assign claim_now  = !link.frame_n && cfg_claim(link.cbe, link.ad, cfg_select);

  // Claim pulse lasts one cycle; function holds until the next claim
  always_comb begin
    next_cfg_hit      = claim_now;
    next_cfg_function = cfg_function;
    if (claim_now) begin
      next_cfg_function = header_multi ? link.ad[FUNC_MSB:FUNC_LSB] : FUNC_RESET;
    end
  end

  // Claim pulse and selected function registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_hit      <= 1'b0;
      cfg_function <= FUNC_RESET;
    end else begin
      cfg_hit      <= next_cfg_hit;
      cfg_function <= next_cfg_function;
    end
  end

  // Claim output driven only while a claim is being made
  assign link.claim_n  = !cfg_hit;
  assign link.claim_oe = cfg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Pipelined request issue and bus state tracking

  // Issue side state
  logic [DEPTH_W-1:0] slot_limit;
  logic [DEPTH_W-1:0] next_outstanding;
  bus_state_e         next_bus_state;
  logic               can_issue;
  logic               granted_start;
  logic               issue;
  logic               next_req_n;
  logic               req_n_q;
  logic [AD_W-1:0]    next_ad;
  logic [CBE_W-1:0]   next_cbe;
  logic               next_pipe_n;
  logic [AD_W-1:0]    ad_q;
  logic [CBE_W-1:0]   cbe_q;
  logic               pipe_q_n;

  // Advertised slots, further capped by the architectural ceiling
  assign slot_limit = (target_slots > MAX_PIPE_DEPTH) ? MAX_PIPE_DEPTH : target_slots;
  assign can_issue  = user_req_valid && user_req_main_mem &&
                      (outstanding < slot_limit);
  assign granted_start = !link.gnt_n && (link.st == ST_START);
  assign issue          = can_issue && granted_start && !req_n_q;
  // Non-main-memory requests are refused here; this end issues no frame transactions
  assign user_req_ready = issue;

  // Next values; an issue and a returned word in one cycle cancel out
  always_comb begin
    next_req_n = !can_issue;
    next_pipe_n = !issue;
    next_ad     = issue ? user_req_addr : ad_q;
    next_cbe    = issue ? user_req_cmd : cbe_q;
    next_outstanding = outstanding;
    if (issue && !link.data_done) begin
      next_outstanding = outstanding + 9'h001;
    end else if (!issue && link.data_done && (outstanding != ZERO_COUNT)) begin
      next_outstanding = outstanding - 9'h001;
    end
    next_bus_state = bus_state;
    // Frame cycles pass through PCI and go back to DATA while words are owed
    unique case (bus_state)
      BUS_IDLE: begin
        if (issue) next_bus_state = BUS_REQUEST;
        else if (!link.frame_n) next_bus_state = BUS_PCI;
      end
      BUS_REQUEST: begin
        if (!issue) next_bus_state = BUS_DATA;
      end
      BUS_PCI: begin
        if (link.frame_n) begin
          next_bus_state = (outstanding != ZERO_COUNT) ? BUS_DATA : BUS_IDLE;
        end
      end
      BUS_DATA: begin
        if (issue) next_bus_state = BUS_REQUEST;
        else if (!link.frame_n) next_bus_state = BUS_PCI;
        else if (next_outstanding == ZERO_COUNT) next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // Request issue and tracker registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_n_q     <= 1'b1;
      pipe_q_n    <= 1'b1;
      ad_q        <= '0;
      cbe_q       <= '0;
      outstanding <= ZERO_COUNT;
      bus_state   <= BUS_IDLE;
    end else begin
      req_n_q     <= next_req_n;
      pipe_q_n    <= next_pipe_n;
      ad_q        <= next_ad;
      cbe_q       <= next_cbe;
      outstanding <= next_outstanding;
      bus_state   <= next_bus_state;
    end
  end

  // Link drive: pipe framing only, the frame line is left to the corelogic
  assign link.req_n               = req_n_q;
  assign link.pipe_n              = pipe_q_n;
  assign link.ad_from_master      = ad_q;
  assign link.ad_oe_master        = !pipe_q_n;
  assign link.cbe_from_master     = cbe_q;
  assign link.cbe_oe_master       = !pipe_q_n;
  assign link.frame_from_master_n = 1'b1;
  assign link.frame_oe_master     = 1'b0;

  // Inbound writes at port rate; outbound memory writes stay at frame rate
  // Only write data heading into the master is sped up
  assign fast_write_active = accelerated_target_write && claim_now &&
                             (link.cbe == CMD_CFG_WRITE);
  // Tells the power logic when the clock may stop
  assign clock_stop_ok     = (bus_state == BUS_IDLE) && (outstanding == ZERO_COUNT);
endmodule // gport_master

// ---- inc/gport_pkg.sv ----
// Shared constants and types for the graphics port configuration and pipeline ends
package gport_pkg;

  // Bus and pipeline count widths
  localparam int unsigned AD_W      = 32;
  localparam int unsigned CBE_W     = 4;
  localparam int unsigned STAT_W    = 3;
  localparam int unsigned DEPTH_W   = 9;

  // Pipeline depth ceiling and a plain default for the target's advertised slots
  localparam logic [DEPTH_W-1:0] MAX_PIPE_DEPTH   = 9'h100;
  localparam logic [DEPTH_W-1:0] DEFAULT_SLOTS    = 9'h008;
  localparam logic [DEPTH_W-1:0] ZERO_COUNT       = 9'h000;

  // Field positions on the address/data lines
  localparam int unsigned CFG_SELECT_BIT = 16;
  localparam int unsigned FUNC_LSB       = 8;
  localparam int unsigned FUNC_MSB       = 10;
  localparam int unsigned HDR_MULTI_BIT  = 7;

  // Command codes on the command lines during a frame address phase or a pipelined request
  localparam logic [CBE_W-1:0] CMD_MEM_READ   = 4'h6;
  localparam logic [CBE_W-1:0] CMD_MEM_WRITE  = 4'h7;
  localparam logic [CBE_W-1:0] CMD_CFG_READ   = 4'hA;
  localparam logic [CBE_W-1:0] CMD_CFG_WRITE  = 4'hB;

  // Status line codes that go with a grant or a data return
  localparam logic [STAT_W-1:0] ST_READ_LOW   = 3'h0;
  localparam logic [STAT_W-1:0] ST_READ_HIGH  = 3'h1;
  localparam logic [STAT_W-1:0] ST_WRITE_LOW  = 3'h2;
  localparam logic [STAT_W-1:0] ST_WRITE_HIGH = 3'h3;
  localparam logic [STAT_W-1:0] ST_START      = 3'h7;

  // Values after reset
  localparam logic [2:0] FUNC_RESET = 3'h0;

  // Shared bus state model
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_REQUEST,
    BUS_PCI,
    BUS_DATA
  } bus_state_e;

  // Configuration claim decode, used by the master end
  function automatic logic cfg_claim(input logic [CBE_W-1:0] cmd,
                                     input logic [AD_W-1:0]  ad,
                                     input logic             select);
    cfg_claim = ((cmd == CMD_CFG_READ) || (cmd == CMD_CFG_WRITE)) &&
                (ad[1:0] == 2'h0) && select;
  endfunction

endpackage

// ---- inc/gport_if.sv ----
// Point-to-point link between the graphics master and the corelogic
`timescale 1ns/10ps
interface gport_if;
  import gport_pkg::*;

  // Shared address/data and command lines, with per-end enables
  logic [AD_W-1:0]   ad_from_master;
  logic              ad_oe_master;
  logic [AD_W-1:0]   ad_from_core;
  logic              ad_oe_core;
  logic [CBE_W-1:0]  cbe_from_master;
  logic              cbe_oe_master;
  logic [CBE_W-1:0]  cbe_from_core;
  logic              cbe_oe_core;
  // Framing and arbitration
  logic              frame_from_core_n;
  logic              frame_oe_core;
  logic              frame_from_master_n;
  logic              frame_oe_master;
  logic              pipe_n;
  logic              req_n;
  logic              gnt_n;
  logic [STAT_W-1:0] st;
  logic              claim_n;
  logic              claim_oe;
  logic              data_done;

  // Resolved wire values
  logic [AD_W-1:0]   ad;
  logic [CBE_W-1:0]  cbe;
  logic              frame_n;
  logic              claim_line_n;

  assign ad           = ad_oe_master ? ad_from_master :
                        (ad_oe_core ? ad_from_core : '0);
  assign cbe          = cbe_oe_master ? cbe_from_master :
                        (cbe_oe_core ? cbe_from_core : '1);
  assign frame_n      = frame_oe_master ? frame_from_master_n :
                        (frame_oe_core ? frame_from_core_n : 1'b1);
  assign claim_line_n = claim_oe ? claim_n : 1'b1;

  modport master (
    output ad_from_master, ad_oe_master, cbe_from_master, cbe_oe_master,
    output frame_from_master_n, frame_oe_master, pipe_n, req_n,
    output claim_n, claim_oe,
    input  ad, cbe, frame_n, gnt_n, st, data_done
  );

  modport core (
    output ad_from_core, ad_oe_core, cbe_from_core, cbe_oe_core,
    output frame_from_core_n, frame_oe_core, gnt_n, st, data_done,
    input  ad, cbe, frame_n, pipe_n, req_n, claim_line_n
  );
endinterface

// ---- rtl/gport_core.sv ----
// Corelogic end: arbiter, grant status, data return and config cycles
`timescale 1ns/10ps
module gport_core (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Link
  gport_if.core                         link,
  // User config cycle port
  input  wire logic                     cfg_start,
  input  wire logic                     cfg_write,
  input  wire logic [gport_pkg::AD_W-1:0] cfg_addr,
  output logic                          cfg_claimed,
  // Data return
  input  wire logic                     data_ready,
  // Status
  output logic [gport_pkg::DEPTH_W-1:0] pending,
  output gport_pkg::bus_state_e         bus_state
);
  import gport_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and tracking

  bus_state_e         next_bus_state;
  logic [DEPTH_W-1:0] next_pending;
  logic               next_gnt_n;
  logic [STAT_W-1:0]  next_st;
  logic               next_done;
  logic               next_frame;
  logic [AD_W-1:0]    next_ad;
  logic               next_claimed;
  logic               gnt_q_n;
  logic [STAT_W-1:0]  st_q;
  logic               done_q;
  logic               frame_q;
  logic [AD_W-1:0]    ad_q;
  logic               enqueue;

  assign enqueue = !link.pipe_n;

  always_comb begin
    // Requests always win the bus; data resumes on the next free cycle
    next_gnt_n = link.req_n;
    next_st    = ST_START;
    // Data ends only at whole-transfer boundaries, never during a frame
    next_done  = (pending != ZERO_COUNT) && data_ready && link.req_n &&
                 link.pipe_n && link.frame_n && !frame_q && !cfg_start && !done_q;
    if (next_done) next_st = ST_READ_LOW;
    next_pending = pending;
    if (enqueue && !done_q) next_pending = pending + 9'h001;
    else if (!enqueue && done_q) next_pending = pending - 9'h001;
    next_frame   = cfg_start && !frame_q;
    next_ad      = cfg_start ? cfg_addr : ad_q;
    // Claim answers one cycle after the frame, when frame_q has already dropped
    next_claimed = !link.claim_line_n;
    next_bus_state = bus_state;
    unique case (bus_state)
      BUS_IDLE:    if (enqueue) next_bus_state = BUS_REQUEST;
                   else if (frame_q) next_bus_state = BUS_PCI;
      BUS_REQUEST: if (!enqueue) next_bus_state = BUS_DATA;
      BUS_PCI:     if (!frame_q) next_bus_state = (pending != ZERO_COUNT) ? BUS_DATA : BUS_IDLE;
      BUS_DATA:    if (enqueue) next_bus_state = BUS_REQUEST;
                   else if (next_pending == ZERO_COUNT) next_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gnt_q_n     <= 1'b1;
      st_q        <= ST_START;
      done_q      <= 1'b0;
      frame_q     <= 1'b0;
      ad_q        <= '0;
      cfg_claimed <= 1'b0;
      pending     <= ZERO_COUNT;
      bus_state   <= BUS_IDLE;
    end else begin
      gnt_q_n     <= next_gnt_n;
      st_q        <= next_st;
      done_q      <= next_done;
      frame_q     <= next_frame;
      ad_q        <= next_ad;
      cfg_claimed <= next_claimed;
      pending     <= next_pending;
      bus_state   <= next_bus_state;
    end
  end

  // Link drive; command reflects write or read config cycle
  assign link.gnt_n             = gnt_q_n;
  assign link.st                = st_q;
  assign link.data_done         = done_q;
  assign link.frame_from_core_n = !frame_q;
  assign link.frame_oe_core     = frame_q;
  assign link.ad_from_core      = ad_q;
  assign link.ad_oe_core        = frame_q;
  assign link.cbe_from_core     = cfg_write ? CMD_CFG_WRITE : CMD_CFG_READ;
  assign link.cbe_oe_core       = frame_q;
endmodule // gport_core

// ---- verif/gport_asserts.sv ----
// Concurrent checks on the link between the graphics master and the corelogic
`timescale 1ns/10ps
module gport_asserts (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  // Link signals
  input  wire logic [gport_pkg::AD_W-1:0]   ad,
  input  wire logic [gport_pkg::CBE_W-1:0]  cbe,
  input  wire logic                         frame_n,
  input  wire logic                         pipe_n,
  input  wire logic                         req_n,
  input  wire logic                         gnt_n,
  input  wire logic [gport_pkg::STAT_W-1:0] st,
  input  wire logic                         claim_line_n,
  input  wire logic                         ad_oe_master,
  input  wire logic                         data_done
);
  import gport_pkg::*;

  // One clock domain; reset silences every check
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Aligned config frame, the only thing a claim may answer
  logic cfg_ok;
  assign cfg_ok = !frame_n && (ad[1:0] == 2'h0) &&
                  ((cbe == CMD_CFG_READ) || (cbe == CMD_CFG_WRITE));

  //////////////////////////////////////////////////
  // Claim side
  a_claim_needs_cfg: assert property ($fell(claim_line_n) |-> $past(cfg_ok))
    else $error("claim without aligned config frame");
  a_claim_refused: assert property (!frame_n && !cfg_ok |=> claim_line_n)
    else $error("claim on a frame that is not an aligned config cycle");

  //////////////////////////////////////////////////
  // Pipelined requests and data return
  a_pipe_not_frame: assert property (!pipe_n |-> frame_n)
    else $error("pipe framing together with frame");
  a_pipe_after_start: assert property ($fell(pipe_n) |-> $past(!gnt_n && st == ST_START))
    else $error("request issued without start grant");
  a_pipe_mem_cmd: assert property (!pipe_n |-> cbe == CMD_MEM_READ || cbe == CMD_MEM_WRITE)
    else $error("pipelined request is not a memory access");
  a_grant_bound: assert property ($fell(req_n) |-> ##[1:4] !gnt_n)
    else $error("bus request not granted in time");
  a_data_gap: assert property (data_done |-> pipe_n && frame_n)
    else $error("data returned inside a transaction");
  a_data_core_owns: assert property (data_done |-> !ad_oe_master)
    else $error("master drives address/data during data return");
endmodule // gport_asserts

// ---- verif/testbench.sv ----
// Testbench joining master and corelogic ends through the link interface
`timescale 1ns/10ps
module testbench;
  import gport_pkg::*;

  // Config case: strap, select, multifunction, address, write, claim, function
  typedef struct packed {
    logic            strap;
    logic            sel;
    logic            multi;
    logic [AD_W-1:0] addr;
    logic            wr;
    logic            hit;
    logic [2:0]      fn;
  } cfg_row_s;

  logic               clock, rst_b, port_mode_strap, ext_cfg_select, header_multi;
  logic               accelerated_target_write, user_req_valid, user_req_main_mem;
  logic               user_req_ready, cfg_hit, port_mode, fast_write_active, clock_stop_ok;
  logic               cfg_start, cfg_write, cfg_claimed, data_ready;
  logic [DEPTH_W-1:0] target_slots, outstanding, pending;
  logic [AD_W-1:0]    user_req_addr, cfg_addr;
  logic [CBE_W-1:0]   user_req_cmd;
  logic [2:0]         cfg_function;
  bus_state_e         m_state, c_state;
  int                 failures, n_compared, cycles, n_taken, n_done;
  cfg_row_s           rows [10];

  gport_if u_gport_if ();

  gport_master u_gport_master (.clock(clock), .rst_b(rst_b), .link(u_gport_if),
    .port_mode_strap(port_mode_strap), .ext_cfg_select(ext_cfg_select),
    .header_multi(header_multi), .target_slots(target_slots),
    .accelerated_target_write(accelerated_target_write), .user_req_valid(user_req_valid),
    .user_req_addr(user_req_addr), .user_req_cmd(user_req_cmd),
    .user_req_main_mem(user_req_main_mem), .user_req_ready(user_req_ready),
    .cfg_hit(cfg_hit), .cfg_function(cfg_function), .outstanding(outstanding),
    .bus_state(m_state), .port_mode(port_mode), .fast_write_active(fast_write_active),
    .clock_stop_ok(clock_stop_ok));

  gport_core u_gport_core (.clock(clock), .rst_b(rst_b), .link(u_gport_if),
    .cfg_start(cfg_start), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_claimed(cfg_claimed), .data_ready(data_ready), .pending(pending),
    .bus_state(c_state));

  gport_asserts u_gport_asserts (.clock(clock), .rst_b(rst_b), .ad(u_gport_if.ad),
    .cbe(u_gport_if.cbe), .frame_n(u_gport_if.frame_n), .pipe_n(u_gport_if.pipe_n),
    .req_n(u_gport_if.req_n), .gnt_n(u_gport_if.gnt_n), .st(u_gport_if.st),
    .claim_line_n(u_gport_if.claim_line_n), .ad_oe_master(u_gport_if.ad_oe_master),
    .data_done(u_gport_if.data_done));

  //////////////////////////////////////////////////
  // 250 MHz clock
  always #2 clock = ~clock;

  // Count taken requests and returned data; a hang ends the run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (user_req_ready === 1'b1) n_taken <= n_taken + 1;
    if (u_gport_if.data_done === 1'b1) n_done <= n_done + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Strap is only taken at the first edge after release, so a mode change needs reset
  task automatic do_reset(input logic strap);
    rst_b <= 1'b0;
    port_mode_strap <= strap;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  // One config frame from the core; claim looked for over a few edges
  task automatic cfg_cycle(input cfg_row_s r);
    logic hit_seen, claim_seen;
    hit_seen = 1'b0;
    claim_seen = 1'b0;
    ext_cfg_select <= r.sel;
    header_multi <= r.multi;
    cfg_addr <= r.addr;
    cfg_write <= r.wr;
    cfg_start <= 1'b1;
    @(posedge clock);
    cfg_start <= 1'b0;
    repeat (5) begin
      @(posedge clock);
      hit_seen = hit_seen | (cfg_hit === 1'b1);
      claim_seen = claim_seen | (cfg_claimed === 1'b1);
    end
    check(port_mode, r.strap);
    check(hit_seen, r.hit);
    check(claim_seen, r.hit);
    if (r.multi) check(cfg_function, r.fn);
  endtask

  // Hold a request up for a number of cycles
  task automatic fill(input logic [DEPTH_W-1:0] slots, input int cyc);
    target_slots <= slots;
    user_req_valid <= 1'b1;
    repeat (cyc) @(posedge clock);
    user_req_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Bounded wait for the pipeline to empty
  task automatic wait_drain();
    int k;
    k = 0;
    while (outstanding !== ZERO_COUNT && k < 2000) begin
      @(posedge clock);
      k++;
    end
    repeat (3) @(posedge clock);
  endtask

  //////////////////////////////////////////////////
  // Main sequence
  initial begin
    rows = '{'{1'h1, 1'h0, 1'h0, 32'h0001_0000, 1'h0, 1'h1, 3'h0},
             '{1'h1, 1'h0, 1'h0, 32'h0001_0000, 1'h1, 1'h1, 3'h0},
             '{1'h1, 1'h0, 1'h0, 32'h0001_0001, 1'h0, 1'h0, 3'h0},
             '{1'h1, 1'h0, 1'h0, 32'h0001_0002, 1'h1, 1'h0, 3'h0},
             '{1'h1, 1'h0, 1'h0, 32'h0002_0000, 1'h0, 1'h0, 3'h0},
             '{1'h1, 1'h1, 1'h0, 32'h8000_0000, 1'h0, 1'h0, 3'h0},
             '{1'h1, 1'h0, 1'h1, 32'h0001_0500, 1'h0, 1'h1, 3'h5},
             '{1'h1, 1'h0, 1'h1, 32'h0001_0700, 1'h1, 1'h1, 3'h7},
             '{1'h0, 1'h1, 1'h0, 32'h0000_0000, 1'h0, 1'h1, 3'h0},
             '{1'h0, 1'h0, 1'h0, 32'h0001_0000, 1'h0, 1'h0, 3'h0}};
    clock = 1'b0;
    rst_b = 1'b0;
    port_mode_strap = 1'b1;
    ext_cfg_select = 1'b0;
    header_multi = 1'b0;
    target_slots = DEFAULT_SLOTS;
    accelerated_target_write = 1'b0;
    user_req_valid = 1'b0;
    user_req_addr = 32'h0000_1000;
    user_req_cmd = CMD_MEM_READ;
    user_req_main_mem = 1'b0;
    cfg_start = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = '0;
    data_ready = 1'b0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    n_taken = 0;
    n_done = 0;
    do_reset(1'b1);
    for (int i = 0; i < 10; i++) begin
      if (rows[i].strap !== port_mode_strap) do_reset(rows[i].strap);
      cfg_cycle(rows[i]);
    end
    // Trackers after reset
    do_reset(1'b1);
    check(m_state, BUS_IDLE);
    check(c_state, BUS_IDLE);
    check(outstanding, ZERO_COUNT);
    check(clock_stop_ok, 1'b1);
    accelerated_target_write <= 1'b1;
    repeat (2) @(posedge clock);
    check(fast_write_active, 1'b0);
    // Claimed write frame: inbound data at port rate while the frame stands
    cfg_addr <= 32'h0001_0000;
    cfg_write <= 1'b1;
    cfg_start <= 1'b1;
    @(posedge clock);
    cfg_start <= 1'b0;
    @(posedge clock);
    check(fast_write_active, 1'b1);
    repeat (3) @(posedge clock);
    // Local-memory request must not enter the pipeline
    fill(9'h003, 10);
    check(n_taken, 0);
    check(outstanding, ZERO_COUNT);
    // Slots full with data held back
    user_req_main_mem <= 1'b1;
    fill(9'h003, 20);
    check(outstanding, 9'h003);
    check(pending, 9'h003);
    check(m_state, BUS_DATA);
    check(c_state, BUS_DATA);
    check(clock_stop_ok, 1'b0);
    // New writes intervene while data flows back
    data_ready <= 1'b1;
    user_req_cmd <= CMD_MEM_WRITE;
    fill(9'h003, 12);
    wait_drain();
    check(n_taken > 3, 1'b1);
    check(n_done, n_taken);
    check(m_state, BUS_IDLE);
    check(c_state, BUS_IDLE);
    check(clock_stop_ok, 1'b1);
    // Advertised slots above the ceiling are capped
    data_ready <= 1'b0;
    fill(9'h1FF, 300);
    check(outstanding, MAX_PIPE_DEPTH);
    data_ready <= 1'b1;
    wait_drain();
    check(pending, ZERO_COUNT);
    stop_test();
  end
endmodule // testbench
